// File: hdl/vwir_top.sv
// register bank, setting select and measurement window generator
// assumes sandcastle key, blanking and field pulse as logic levels
module vwir_top #(
	parameter int CODE_W = 6,
	parameter int LCNT_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic addr_select_pin_i,
	input wire logic burst_clamp_key_i,
	input wire logic sandcastle_blank_i,
	input wire logic sandcastle_field_i,
	input wire logic default_window_pin_i,
	input wire logic range_select_pin_i,
	input wire logic offset_switch_pin_i,
	input wire logic [CODE_W-1:0] gamma_level_pin_i,
	input wire logic [CODE_W-1:0] adaptive_gain_pin_i,
	input wire logic [CODE_W-1:0] linearity_level_pin_i,
	output logic range_select_o,
	output logic black_comp_enable_o,
	output logic [CODE_W-1:0] gamma_code_o,
	output logic [CODE_W-1:0] adaptive_code_o,
	output logic [CODE_W-1:0] nonlinear_code_o,
	output vwir_pkg::vwir_wsrc_t window_source_o,
	output logic meas_window_o,
	output logic black_meas_en_o,
	output logic hist_meas_en_o,
	output logic input_clamp_o
);
	import vwir_pkg::*;

	localparam int PIN_W = 7 + 3 * CODE_W;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [PIN_W-1:0] pin_sy1_r, pin_sy2_r;
	logic key_s, blank_s, field_s, dws_s, range_s, bof_s, adr_s;
	logic [CODE_W-1:0] gam_s, agam_s, lin_s;

	// every pin is asynchronous to the clock, two stages each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sy1_r <= '0;
			pin_sy2_r <= '0;
		end else begin
			pin_sy1_r <= {burst_clamp_key_i, sandcastle_blank_i,
				sandcastle_field_i, default_window_pin_i,
				range_select_pin_i, offset_switch_pin_i,
				addr_select_pin_i, gamma_level_pin_i,
				adaptive_gain_pin_i, linearity_level_pin_i};
			pin_sy2_r <= pin_sy1_r;
		end
	end

	assign {key_s, blank_s, field_s, dws_s, range_s, bof_s, adr_s,
		gam_s, agam_s, lin_s} = pin_sy2_r;

	// ------------------------------------------------------------
	// serial bus slave and register file
	// ------------------------------------------------------------
	logic wr_stb, rd_stb;
	logic [7:0] wr_sub, wr_data, status_w;
	logic [7:0] reg_r [NUM_REGS];
	logic [7:0] reg_nxt [NUM_REGS];
	logic por_r, por_nxt;

	vwir_i2c_slave vwir_i2c_slave_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.addr_lsb_i(adr_s),
		.rd_data_i(status_w),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.wr_stb_o(wr_stb),
		.wr_sub_o(wr_sub),
		.wr_data_o(wr_data),
		.rd_stb_o(rd_stb)
	);

	// undefined status bits read as zero
	always_comb begin
		status_w = 8'h00;
		status_w[STAT_POR] = por_r;
	end

	// indexed write; the slave already refused unmapped sub-addresses
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			reg_nxt[i] = reg_r[i];
		end
		if (wr_stb && vwir_sub_ok(wr_sub)) begin
			reg_nxt[wr_sub[2:0]] = wr_data;
		end
		// power-on flag drops once it has been read out
		por_nxt = por_r & ~rd_stb;
	end

	// reset to pin control and default windows
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				reg_r[i] <= REG_RST[i*8 +: 8];
			end
			por_r <= 1'b1;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				reg_r[i] <= reg_nxt[i];
			end
			por_r <= por_nxt;
		end
	end

	// ------------------------------------------------------------
	// setting select: pins or bus
	// ------------------------------------------------------------
	logic ovr_w;
	logic range_nxt, black_nxt;
	logic [CODE_W-1:0] gam_nxt, agam_nxt, lin_nxt;
	vwir_wsrc_t wsrc_nxt, wsrc_r;

	assign ovr_w = reg_r[SUB_CTRL[2:0]][CTRL_OVR];

	always_comb begin
		if (ovr_w) begin
			range_nxt = reg_r[SUB_CTRL[2:0]][CTRL_RANGE];
			black_nxt = reg_r[SUB_CTRL[2:0]][CTRL_BLACK];
			gam_nxt = reg_r[SUB_VGAM[2:0]][CODE_W-1:0];
			agam_nxt = reg_r[SUB_AGAM[2:0]][CODE_W-1:0];
			lin_nxt = reg_r[SUB_NLIN[2:0]][CODE_W-1:0];
			if (reg_r[SUB_CTRL[2:0]][CTRL_WSEL_HI]) begin
				wsrc_nxt = WSRC_USER;
			end else if (reg_r[SUB_CTRL[2:0]][CTRL_WSEL_LO]) begin
				wsrc_nxt = WSRC_BLANK;
			end else begin
				wsrc_nxt = WSRC_DEFAULT;
			end
		end else begin
			range_nxt = range_s;
			black_nxt = bof_s;
			gam_nxt = gam_s;
			agam_nxt = agam_s;
			lin_nxt = lin_s;
			// pin high picks the default window
			wsrc_nxt = dws_s ? WSRC_DEFAULT : WSRC_BLANK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			range_select_o <= 1'b0;
			black_comp_enable_o <= 1'b0;
			gamma_code_o <= '0;
			adaptive_code_o <= '0;
			nonlinear_code_o <= '0;
			wsrc_r <= WSRC_DEFAULT;
		end else begin
			range_select_o <= range_nxt;
			black_comp_enable_o <= black_nxt;
			gamma_code_o <= gam_nxt;
			adaptive_code_o <= agam_nxt;
			nonlinear_code_o <= lin_nxt;
			wsrc_r <= wsrc_nxt;
		end
	end

	assign window_source_o = wsrc_r;

	// ------------------------------------------------------------
	// horizontal window: 128ths of the measured line period
	// ------------------------------------------------------------
	logic key_q_r, field_q_r, key_rise, key_fall, field_rise;
	logic [LCNT_W-1:0] lcnt_r, lcnt_nxt, period_r, period_nxt;
	logic [LCNT_W-1:0] frac_r, frac_nxt, step_w;
	logic [7:0] hpos_r, hpos_nxt, h_start, h_stop, line_code;
	logic line_win;

	assign key_rise = key_s & ~key_q_r;
	assign key_fall = ~key_s & key_q_r;
	assign field_rise = field_s & ~field_q_r;
	// a period under 128 clocks still steps once per clock
	assign step_w = (period_r >> LINE_FRAC_SHIFT) == '0 ?
		LCNT_W'(1) : period_r >> LINE_FRAC_SHIFT;

	always_comb begin
		lcnt_nxt = (&lcnt_r) ? lcnt_r : lcnt_r + LCNT_W'(1);
		period_nxt = period_r;
		frac_nxt = frac_r + LCNT_W'(1);
		hpos_nxt = hpos_r;
		if (frac_nxt >= step_w) begin
			frac_nxt = '0;
			hpos_nxt = (&hpos_r) ? hpos_r : hpos_r + 8'h01;
		end
		if (key_rise) begin
			lcnt_nxt = '0;
			period_nxt = lcnt_r;
			frac_nxt = '0;
			hpos_nxt = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_q_r <= 1'b0;
			field_q_r <= 1'b0;
			lcnt_r <= '0;
			period_r <= '0;
			frac_r <= '0;
			hpos_r <= 8'hff;
		end else begin
			key_q_r <= key_s;
			field_q_r <= field_s;
			lcnt_r <= lcnt_nxt;
			period_r <= period_nxt;
			frac_r <= frac_nxt;
			hpos_r <= hpos_nxt;
		end
	end

	// default codes when not user window
	assign line_code = (wsrc_r == WSRC_USER) ? reg_r[SUB_LINE[2:0]] : LINE_RST;
	// start 4.5 plus 1 per step, stop 26.5 plus 2
	assign h_start = LINE_START_BASE + LINE_START_STEP * {4'h0, line_code[7:4]};
	assign h_stop = LINE_STOP_BASE + LINE_STOP_STEP * {4'h0, line_code[3:0]};
	assign line_win = (hpos_r >= h_start) && (hpos_r < h_stop);

	// ------------------------------------------------------------
	// vertical window: lines after first key following field pulse
	// ------------------------------------------------------------
	logic armed_r, armed_nxt, vrun_r, vrun_nxt;
	logic [9:0] vcnt_r, vcnt_nxt, v_start, v_end;
	logic [7:0] field_code;
	logic field_win, win_nxt, win_r, clamp_nxt;

	always_comb begin
		armed_nxt = armed_r;
		vrun_nxt = vrun_r;
		vcnt_nxt = vcnt_r;
		if (key_fall && armed_r) begin
			armed_nxt = 1'b0;
			vrun_nxt = 1'b1;
			vcnt_nxt = 10'h000;
		end else if (key_fall && vrun_r && !(&vcnt_r)) begin
			vcnt_nxt = vcnt_r + 10'h001;
		end
		// a new field pulse wins over the key in the same cycle
		if (field_rise) begin
			armed_nxt = 1'b1;
		end
	end

	assign field_code = (wsrc_r == WSRC_USER) ?
		reg_r[SUB_FIELD[2:0]] : FIELD_RST;
	// start 10 plus 6 lines per step
	assign v_start = FIELD_START_BASE
		+ FIELD_START_STEP * {6'h00, field_code[7:4]};
	// stop counted from the window start v_start, not from the start event
	assign v_end = v_start + FIELD_STOP_BASE
		+ FIELD_STOP_STEP * {6'h00, field_code[3:0]};
	assign field_win = vrun_r && (vcnt_r >= v_start) && (vcnt_r < v_end);

	always_comb begin
		if (wsrc_r == WSRC_BLANK) begin
			win_nxt = ~blank_s;
		end else begin
			win_nxt = line_win & field_win;
		end
		clamp_nxt = key_s;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
			vrun_r <= 1'b0;
			vcnt_r <= 10'h000;
			win_r <= 1'b0;
			input_clamp_o <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			vrun_r <= vrun_nxt;
			vcnt_r <= vcnt_nxt;
			win_r <= win_nxt;
			input_clamp_o <= clamp_nxt;
		end
	end

	assign meas_window_o = win_r;
	assign black_meas_en_o = win_r;
	assign hist_meas_en_o = win_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_field_start;
		armed_r && key_fall;
	endsequence

	property p_sub_range;
		wr_stb |-> wr_sub <= SUB_LAST;
	endproperty
	a_sub_range: assert property (p_sub_range)
		else $error("write to unmapped sub-address");

	property p_pin_range;
		!ovr_w |=> range_select_o == $past(range_s);
	endproperty
	a_pin_range: assert property (p_pin_range)
		else $error("range does not follow pin under pin control");

	property p_user_win;
		ovr_w && reg_r[0][CTRL_WSEL_HI] |=> wsrc_r == WSRC_USER;
	endproperty
	a_user_win: assert property (p_user_win)
		else $error("user window not selected");

	property p_gate_both;
		wsrc_r == WSRC_BLANK |=> black_meas_en_o == !$past(blank_s)
			&& hist_meas_en_o == black_meas_en_o;
	endproperty
	a_gate_both: assert property (p_gate_both)
		else $error("measurement gates do not follow blanking");

	property p_line_sync;
		key_rise |=> hpos_r == 8'h00 ##1 hpos_r <= 8'h01;
	endproperty
	a_line_sync: assert property (p_line_sync)
		else $error("line position not restarted by key edge");

	property p_field_sync;
		s_field_start ##0 !field_rise |=> vrun_r && vcnt_r == 10'h000 && !armed_r;
	endproperty
	a_field_sync: assert property (p_field_sync)
		else $error("field count not restarted by first key fall");

	property p_clamp;
		key_s |=> input_clamp_o;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("clamp not asserted with key");

	property p_reset_vals;
		$past(rst_i) |-> reg_r[4] == LINE_RST && reg_r[5] == FIELD_RST
			&& !ovr_w && por_r;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("register reset values wrong");

	property p_por_read;
		rd_stb |=> !por_r [*2];
	endproperty
	a_por_read: assert property (p_por_read)
		else $error("power-on flag not cleared by read");

endmodule : vwir_top

// File: inc/vwir_pkg.sv
// constants, types and decode helpers of the video window register bank
// assumes one 25 MHz clock and a synchronous active-high reset
package vwir_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] SUB_CTRL = 8'h00;
	localparam logic [7:0] SUB_VGAM = 8'h01;
	localparam logic [7:0] SUB_AGAM = 8'h02;
	localparam logic [7:0] SUB_NLIN = 8'h03;
	localparam logic [7:0] SUB_LINE = 8'h04;
	localparam logic [7:0] SUB_FIELD = 8'h05;
	localparam logic [7:0] SUB_LAST = 8'h05;
	localparam int NUM_REGS = 6;
	localparam logic [5:0] SLV_ADDR_HI = 6'h34;

	// control bit positions and status layout
	localparam int CTRL_OVR = 0;
	localparam int CTRL_RANGE = 1;
	localparam int CTRL_WSEL_HI = 2;
	localparam int CTRL_WSEL_LO = 3;
	localparam int CTRL_BLACK = 4;
	localparam int STAT_POR = 0;

	// reset values: pin control, mid-scale codes, default windows
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CODE_RST = 8'h20;
	localparam logic [7:0] LINE_RST = 8'h2e;
	localparam logic [7:0] FIELD_RST = 8'h94;
	localparam logic [47:0] REG_RST = {FIELD_RST, LINE_RST, CODE_RST,
		CODE_RST, CODE_RST, CTRL_RST};

	// ------------------------------------------------------------
	// window timing, line in 128ths, field in lines
	// ------------------------------------------------------------
	localparam int LINE_FRAC_SHIFT = 7;
	localparam logic [7:0] LINE_START_BASE = 8'h09;
	localparam logic [7:0] LINE_START_STEP = 8'h02;
	localparam logic [7:0] LINE_STOP_BASE = 8'h35;
	localparam logic [7:0] LINE_STOP_STEP = 8'h04;
	localparam logic [9:0] FIELD_START_BASE = 10'h00a;
	localparam logic [9:0] FIELD_START_STEP = 10'h006;
	localparam logic [9:0] FIELD_STOP_BASE = 10'h079;
	localparam logic [9:0] FIELD_STOP_STEP = 10'h00a;

	typedef enum logic [1:0] {
		WSRC_DEFAULT = 2'b00,
		WSRC_BLANK = 2'b01,
		WSRC_USER = 2'b11
	} vwir_wsrc_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_RECV = 3'b001,
		I2C_ACK = 3'b011,
		I2C_SEND = 3'b010,
		I2C_RACK = 3'b110
	} vwir_i2c_st_t;

	// sub-address inside the mapped range
	function automatic logic vwir_sub_ok(input logic [7:0] sub);
		return sub <= SUB_LAST;
	endfunction : vwir_sub_ok

endpackage : vwir_pkg

// File: hdl/vwir_i2c_slave.sv
// serial bus slave: address match, sub-address, writes, status read
// assumes scl and sda arrive from pins; open-drain drive is low-only
module vwir_i2c_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic addr_lsb_i,
	input wire logic [7:0] rd_data_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic wr_stb_o,
	output logic [7:0] wr_sub_o,
	output logic [7:0] wr_data_o,
	output logic rd_stb_o
);
	import vwir_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers and bus events
	// ------------------------------------------------------------
	logic [1:0] scl_sy_r, sda_sy_r;
	logic scl_q_r, sda_q_r, scl_s, sda_s;
	logic scl_rise, scl_fall, start_w, stop_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_sy_r <= {scl_sy_r[0], scl_i};
			sda_sy_r <= {sda_sy_r[0], sda_i};
			scl_q_r <= scl_sy_r[1];
			sda_q_r <= sda_sy_r[1];
		end
	end

	assign scl_s = scl_sy_r[1];
	assign sda_s = sda_sy_r[1];
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_w = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_w = scl_s & scl_q_r & ~sda_q_r & sda_s;

	// ------------------------------------------------------------
	// byte engine
	// ------------------------------------------------------------
	vwir_i2c_st_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] shift_r, shift_nxt, sub_r, sub_nxt;
	logic [1:0] phase_r, phase_nxt;
	logic read_r, read_nxt, drive_r, drive_nxt;
	logic wr_stb_r, wr_stb_nxt, rd_stb_r, rd_stb_nxt;
	logic [7:0] wr_sub_r, wr_sub_nxt, wr_data_r, wr_data_nxt;

	// next state; start and stop override any byte in flight
	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		sub_nxt = sub_r;
		phase_nxt = phase_r;
		read_nxt = read_r;
		drive_nxt = drive_r;
		wr_stb_nxt = 1'b0;
		rd_stb_nxt = 1'b0;
		wr_sub_nxt = wr_sub_r;
		wr_data_nxt = wr_data_r;
		if (start_w) begin
			st_nxt = I2C_RECV;
			bit_nxt = 4'h0;
			phase_nxt = 2'h0;
			read_nxt = 1'b0;
			drive_nxt = 1'b0;
		end else if (stop_w) begin
			st_nxt = I2C_IDLE;
			drive_nxt = 1'b0;
		end else begin
			unique case (st_r)
				I2C_IDLE: begin
				end
				I2C_RECV: begin
					if (scl_rise && bit_r != 4'h8) begin
						shift_nxt = {shift_r[6:0], sda_s};
						bit_nxt = bit_r + 4'h1;
					end
					if (scl_fall && bit_r == 4'h8) begin
						bit_nxt = 4'h0;
						st_nxt = I2C_ACK;
						drive_nxt = 1'b1;
						unique case (phase_r)
							2'h0: begin
								if (shift_r[7:1] == {SLV_ADDR_HI, addr_lsb_i}) begin
									read_nxt = shift_r[0];
									phase_nxt = 2'h1;
								end else begin
									st_nxt = I2C_IDLE;
									drive_nxt = 1'b0;
								end
							end
							2'h1: begin
								sub_nxt = shift_r;
								phase_nxt = 2'h2;
								if (!vwir_sub_ok(shift_r)) begin
									st_nxt = I2C_IDLE;
									drive_nxt = 1'b0;
								end
							end
							default: begin
								if (vwir_sub_ok(sub_r)) begin
									wr_stb_nxt = 1'b1;
									wr_sub_nxt = sub_r;
									wr_data_nxt = shift_r;
									sub_nxt = sub_r + 8'h01;
								end else begin
									st_nxt = I2C_IDLE;
									drive_nxt = 1'b0;
								end
							end
						endcase
					end
				end
				I2C_ACK, I2C_RACK: begin
					if (st_r == I2C_RACK && scl_rise && sda_s) begin
						st_nxt = I2C_IDLE;
					end else if (scl_fall) begin
						if (read_r) begin
							st_nxt = I2C_SEND;
							shift_nxt = rd_data_i;
							drive_nxt = ~rd_data_i[7];
							rd_stb_nxt = 1'b1;
						end else begin
							st_nxt = I2C_RECV;
							drive_nxt = 1'b0;
						end
						bit_nxt = 4'h0;
					end
				end
				I2C_SEND: begin
					if (scl_fall) begin
						if (bit_r == 4'h7) begin
							st_nxt = I2C_RACK;
							drive_nxt = 1'b0;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							drive_nxt = ~shift_r[6];
							bit_nxt = bit_r + 4'h1;
						end
					end
				end
				default: begin
					st_nxt = I2C_IDLE;
					drive_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= I2C_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			sub_r <= 8'h00;
			phase_r <= 2'h0;
			read_r <= 1'b0;
			drive_r <= 1'b0;
			wr_stb_r <= 1'b0;
			rd_stb_r <= 1'b0;
			wr_sub_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			sub_r <= sub_nxt;
			phase_r <= phase_nxt;
			read_r <= read_nxt;
			drive_r <= drive_nxt;
			wr_stb_r <= wr_stb_nxt;
			rd_stb_r <= rd_stb_nxt;
			wr_sub_r <= wr_sub_nxt;
			wr_data_r <= wr_data_nxt;
		end
	end

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~drive_r;
	assign wr_stb_o = wr_stb_r;
	assign wr_sub_o = wr_sub_r;
	assign wr_data_o = wr_data_r;
	assign rd_stb_o = rd_stb_r;

endmodule : vwir_i2c_slave

// File: test/vwir_i2c_master.sv
// serial bus master model, bit-banged on the system clock
// assumes a pulled-up data wire resolved by the bench
module vwir_i2c_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus: clock stands high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick

	// start or repeated start: data falls while clock high
	task automatic start();
		sda_low_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask : start

	task automatic stop();
		tick(2);
		sda_low_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b0;
		tick(4);
	endtask : stop

	// sampled late in the high phase: slave answers through synchronisers
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_low_o = !b;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		r = sda_i;
		scl_o = 1'b0;
	endtask : bit_io

	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : send

	task automatic recv(input logic ack_it, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!ack_it, r);
	endtask : recv
endmodule : vwir_i2c_master

// File: test/video_window_i2c_regs_tb_top.sv
// self-checking bench of the video window register bank
// assumes the master model drives the bus; pins driven on falling edges
module video_window_i2c_regs_tb_top import vwir_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] WADR = {SLV_ADDR_HI, 1'b1, 1'b0};
	logic clk_i, rst_i, scl, sda_low, sda_w, key, blank, field;
	logic default_window_pin, rng, ofs, sda_o, sda_oe_n_o, rng_o, blk_o, win_o, bm_o, hm_o;
	logic clamp_o, adr;
	logic [5:0] gam, agn, lin, gam_o, agn_o, lin_o;
	vwir_wsrc_t src_o;
	int err_count, checks_done;

	// pull-up wins unless someone pulls low
	assign sda_w = !sda_low && (sda_oe_n_o || sda_o);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	vwir_top vwir_top_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
		.addr_select_pin_i(adr), .burst_clamp_key_i(key),
		.sandcastle_blank_i(blank), .sandcastle_field_i(field),
		.default_window_pin_i(default_window_pin), .range_select_pin_i(rng),
		.offset_switch_pin_i(ofs), .gamma_level_pin_i(gam),
		.adaptive_gain_pin_i(agn), .linearity_level_pin_i(lin),
		.range_select_o(rng_o), .black_comp_enable_o(blk_o),
		.gamma_code_o(gam_o), .adaptive_code_o(agn_o),
		.nonlinear_code_o(lin_o), .window_source_o(src_o),
		.meas_window_o(win_o), .black_meas_en_o(bm_o),
		.hist_meas_en_o(hm_o), .input_clamp_o(clamp_o));

	vwir_i2c_master vwir_i2c_master_inst (.clk_i(clk_i), .sda_i(sda_w),
		.scl_o(scl), .sda_low_o(sda_low));

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wait_n

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string w);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, w, got, exp);
		end
	endtask : chk

	task automatic snd(input logic [7:0] d, input logic exp, input string w);
		logic a;
		vwir_i2c_master_inst.send(d, a);
		chk({7'h0, a}, {7'h0, exp}, w);
	endtask : snd

	// one write transfer from a sub-address, every byte acknowledged
	task automatic wr(input logic [7:0] sub, input logic [7:0] q[$]);
		vwir_i2c_master_inst.start();
		snd(WADR, 1'b1, "addr ack");
		snd(sub, 1'b1, "sub ack");
		foreach (q[i]) snd(q[i], 1'b1, "data ack");
		vwir_i2c_master_inst.stop();
		wait_n(6);
	endtask : wr

	task automatic t_status();
		logic [7:0] d;
		vwir_i2c_master_inst.start();
		snd(WADR | 8'h01, 1'b1, "read addr ack");
		vwir_i2c_master_inst.recv(1'b1, d);
		chk({7'h0, d[0]}, 8'h01, "power-on flag");
		vwir_i2c_master_inst.recv(1'b0, d);
		chk({7'h0, d[0]}, 8'h00, "flag cleared");
		vwir_i2c_master_inst.stop();
		$display("t_status done");
	endtask : t_status

	// settings follow the pins straight after reset
	task automatic t_pins();
		rng = 1'b1;
		ofs = 1'b1;
		default_window_pin = 1'b1;
		wait_n(4);
		chk({6'h0, blk_o, rng_o}, 8'h03, "range/offset pins");
		chk({2'h0, gam_o}, 8'h15, "gamma pin");
		chk({2'h0, agn_o}, 8'h2a, "adaptive pin");
		chk({2'h0, lin_o}, 8'h07, "linearity pin");
		chk({6'h0, src_o}, {6'h0, WSRC_DEFAULT}, "default pin");
		default_window_pin = 1'b0;
		wait_n(4);
		chk({6'h0, src_o}, {6'h0, WSRC_BLANK}, "blank format");
		for (int b = 0; b < 2; b++) begin
			blank = b[0];
			key = b[0];
			wait_n(4);
			chk({5'h0, win_o, bm_o, hm_o}, b ? 8'h00 : 8'h07, "gates");
			chk({7'h0, clamp_o}, {7'h0, b[0]}, "clamp");
		end
		$display("t_pins done");
	endtask : t_pins

	task automatic t_write();
		logic [7:0] c[4] = '{8'h13, 8'h09, 8'h05, 8'h0d};
		vwir_wsrc_t s[4] = '{WSRC_DEFAULT, WSRC_BLANK, WSRC_USER, WSRC_USER};
		rng = 1'b0;
		ofs = 1'b0;
		wr(SUB_CTRL, '{8'h1b, 8'hff, 8'h05, 8'hc9});
		chk({6'h0, blk_o, rng_o}, 8'h03, "bus range/black");
		chk({6'h0, src_o}, {6'h0, WSRC_BLANK}, "bus window");
		chk({2'h0, gam_o}, 8'h3f, "gamma reg");
		chk({2'h0, agn_o}, 8'h05, "adaptive reg");
		chk({2'h0, lin_o}, 8'h09, "linearity reg");
		for (int i = 0; i < 4; i++) begin
			wr(SUB_CTRL, '{c[i]});
			chk({6'h0, src_o}, {6'h0, s[i]}, "window select");
			chk({6'h0, blk_o, rng_o}, {6'h0, c[i][4], c[i][1]}, "ctrl");
		end
		wr(SUB_CTRL, '{CTRL_RST});
		chk({2'h0, gam_o}, 8'h15, "back to pins");
		$display("t_write done");
	endtask : t_write

	task automatic t_refuse();
		adr = 1'b0;
		wait_n(4);
		vwir_i2c_master_inst.start();
		snd({SLV_ADDR_HI, 1'b0, 1'b0}, 1'b1, "pin addr");
		vwir_i2c_master_inst.stop();
		adr = 1'b1;
		wait_n(4);
		vwir_i2c_master_inst.start();
		snd({SLV_ADDR_HI, 1'b0, 1'b0}, 1'b0, "foreign addr");
		vwir_i2c_master_inst.stop();
		vwir_i2c_master_inst.start();
		snd(WADR, 1'b1, "addr ack");
		snd(8'h06, 1'b0, "sub 06 refused");
		vwir_i2c_master_inst.stop();
		vwir_i2c_master_inst.start();
		snd(WADR, 1'b1, "addr ack");
		snd(SUB_FIELD, 1'b1, "sub 05 ack");
		snd(FIELD_RST, 1'b1, "field ack");
		snd(8'h01, 1'b0, "past last sub");
		vwir_i2c_master_inst.stop();
		wait_n(6);
		chk({2'h0, gam_o}, 8'h15, "nothing stray");
		$display("t_refuse done");
	endtask : t_refuse

	// user window, line and field codes zero: lines 128 clocks, field pulse on line 1
	task automatic t_window();
		key = 1'b0;
		wr(SUB_CTRL, '{8'h05, 8'h20, 8'h20, 8'h20, 8'h00, 8'h00});
		for (int n = 0; n < 13; n++) begin
			field = (n == 1);
			key = 1'b1;
			wait_n(8);
			key = 1'b0;
			wait_n(26);
			// position 30: count n-1 reaches start 10 on line 11
			chk({5'h0, win_o, bm_o, hm_o}, n > 10 ? 8'h07 : 8'h00, "in");
			wait_n(70);
			chk({5'h0, win_o, bm_o, hm_o}, 8'h00, "past stop");
			wait_n(24);
		end
		$display("t_window done");
	endtask : t_window

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	// all pins defined at time zero, reset held two cycles
	initial begin
		{rst_i, key, blank, field, default_window_pin, rng, ofs} = 7'h41;
		{gam, agn, lin} = {6'h15, 6'h2a, 6'h07};
		adr = 1'b1;
		wait_n(2);
		rst_i = 1'b0;
		wait_n(4);
		t_status();
		t_pins();
		t_write();
		t_refuse();
		t_window();
		finish_test();
	end

	// run needs about 5000 cycles; a hang is cut well after
	initial begin
		repeat (30000) @(posedge clk_i);
		err_count++;
		finish_test();
	end
endmodule : video_window_i2c_regs_tb_top
